// >>> hdl/fuse_signature_config_store.sv
module fuse_signature_config_store
  import fuse_store_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary value
  parameter logic [7:0] CAL_8M_BYTE = 8'h80,
  parameter logic [7:0] CAL_6M4_BYTE = 8'h70
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [7:0] active_low_fuse_out,
  output logic [7:0] active_high_fuse_out,
  output logic self_program_enable_fuse_out,
  output logic eeprom_preserve_fuse_out,
  output logic [7:0] oscillator_calibration_register_out,
  output logic calibration_done_out
);

  fuse_set_t stored_reg;
  fuse_set_t active_reg;
  logic [7:0] lock_reg;
  logic prog_mode_reg;
  logic hv_mode_reg;
  logic legacy_reg;
  logic [1:0] variant_reg;
  logic refused_reg;
  logic [7:0] osc_cal_reg;
  cal_state_t cal_state_reg;
  logic [5:0] imp_sel_reg;
  logic [11:0] flash_addr_reg;
  logic [8:0] ee_addr_reg;
  logic ee_preserve_reg;

  // write channel capture: address and data may arrive in either order
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  logic do_write;
  logic fuse_locked;
  logic hv_only;
  logic fuse_write_ok;
  logic [7:0] wbyte;
  logic [7:0] high_wr;
  logic [7:0] imp_data;
  logic [7:0] rd_data;
  logic rd_hit;
  logic [11:0] flash_split;
  logic [8:0] ee_split;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  assign wbyte = w_strb_reg[0] ? w_data_reg[7:0] : 8'hFF;
  assign fuse_locked = !lock_reg[LOCK_FIRST_BIT];
  assign hv_only = !stored_reg.high[HI_RESET_DISABLE_BIT]
                   || !stored_reg.high[HI_DEBUG_ENABLE_BIT];
  // fuses move only inside programming mode, unlocked, in an allowed mode
  assign fuse_write_ok = prog_mode_reg && !fuse_locked
                         && (hv_mode_reg || !hv_only);

  always_comb begin
    high_wr = wbyte;
    if (!hv_mode_reg) begin
      high_wr[HI_SERIAL_DL_BIT] = stored_reg.high[HI_SERIAL_DL_BIT];
    end
  end

  // imprint table; reserved addresses give a filler nobody may rely on
  always_comb begin
    unique case (imp_sel_reg)
      IMP_SIG0: imp_data = SIG_BYTE0;
      IMP_CAL_8M: imp_data = CAL_8M_BYTE;
      IMP_SIG1: imp_data = SIG_BYTE1;
      IMP_CAL_6M4: imp_data = CAL_6M4_BYTE;
      IMP_SIG2: imp_data = SIG_BYTE2;
      default: imp_data = IMP_RESERVED_DATA;
    endcase
  end

  // page split: flash page in [27:16], word in [4:0]; eeprom page in [24:16], byte in [1:0]
  always_comb begin
    flash_split = '0;
    if (variant_reg == VARIANT_SMALL) begin
      flash_split = {4'h0, flash_addr_reg[11:FLASH_WORD_BITS_SMALL]};
    end else begin
      flash_split = {5'h00, flash_addr_reg[11:FLASH_WORD_BITS_LARGE]};
    end
    ee_split = {2'h0, ee_addr_reg[8:EE_BYTE_BITS]};
  end

  assign ctrl_word = {26'h0, variant_reg, 1'b0, legacy_reg, hv_mode_reg, prog_mode_reg};
  assign status_word = {29'h0, refused_reg, hv_only, fuse_locked};

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr_in)
      ADDR_FUSE_LOW: rd_data = stored_reg.low;
      ADDR_FUSE_HIGH: rd_data = stored_reg.high;
      ADDR_FUSE_EXT: rd_data = stored_reg.ext;
      ADDR_LOCK: rd_data = lock_reg;
      ADDR_ACTIVE_LOW: rd_data = active_reg.low;
      ADDR_ACTIVE_HIGH: rd_data = active_reg.high;
      ADDR_ACTIVE_EXT: rd_data = active_reg.ext;
      ADDR_OSC_CAL: rd_data = osc_cal_reg;
      ADDR_IMPRINT_SEL: rd_data = {2'h0, imp_sel_reg};
      // signature and calibration readable regardless of lock state
      ADDR_IMPRINT_DATA: rd_data = imp_data;
      default: begin
        rd_data = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // axi write address/data capture
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held_reg && !s_axi_awready_out;
      s_axi_wready_out <= !w_held_reg && !s_axi_wready_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (aw_addr_reg <= ADDR_EE_SPLIT) ? 2'b00 : 2'b10;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // read channel: one cycle to answer
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= 2'b00;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= rd_hit ? 2'b00 : 2'b10;
        unique case (s_axi_araddr_in)
          ADDR_CTRL: s_axi_rdata_out <= ctrl_word;
          ADDR_STATUS: s_axi_rdata_out <= status_word;
          ADDR_FLASH_ADDR: s_axi_rdata_out <= {20'h0, flash_addr_reg};
          ADDR_FLASH_SPLIT: s_axi_rdata_out <= {4'h0, flash_split, 11'h0,
                                                (variant_reg == VARIANT_SMALL)
                                                ? {1'b0, flash_addr_reg[3:0]}
                                                : flash_addr_reg[4:0]};
          ADDR_EE_ADDR: s_axi_rdata_out <= {23'h0, ee_addr_reg};
          ADDR_EE_SPLIT: s_axi_rdata_out <= {7'h00, ee_split, 14'h0, ee_addr_reg[1:0]};
          default: s_axi_rdata_out <= {24'h0, rd_data};
        endcase
        if (s_axi_araddr_in == ADDR_CTRL || s_axi_araddr_in == ADDR_STATUS
            || s_axi_araddr_in == ADDR_FLASH_ADDR || s_axi_araddr_in == ADDR_FLASH_SPLIT
            || s_axi_araddr_in == ADDR_EE_ADDR || s_axi_araddr_in == ADDR_EE_SPLIT) begin
          s_axi_rresp_out <= 2'b00;
        end
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // nonvolatile fuse and lock storage; chip erase resets lock only
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stored_reg <= FUSE_SET_RESET;
      lock_reg <= LOCK_RESET;
      refused_reg <= 1'b0;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        ADDR_FUSE_LOW: begin
          if (fuse_write_ok) begin
            stored_reg.low <= wbyte;
          end
          refused_reg <= !fuse_write_ok;
        end
        ADDR_FUSE_HIGH: begin
          if (fuse_write_ok) begin
            stored_reg.high <= high_wr;
          end
          refused_reg <= !fuse_write_ok;
        end
        ADDR_FUSE_EXT: begin
          if (fuse_write_ok) begin
            stored_reg.ext <= {7'h7F, wbyte[EXT_SELF_PROG_BIT]};
          end
          refused_reg <= !fuse_write_ok;
        end
        ADDR_LOCK: begin
          // lock bits only move toward programmed; only erase or reset clears them
          if (prog_mode_reg && !(hv_only && !hv_mode_reg)) begin
            lock_reg <= lock_reg & wbyte;
          end
        end
        ADDR_CTRL: begin
          if (w_data_reg[CTRL_CHIP_ERASE_BIT] && prog_mode_reg) begin
            lock_reg <= LOCK_RESET;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // control register and address registers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prog_mode_reg <= 1'b0;
      hv_mode_reg <= 1'b0;
      legacy_reg <= 1'b0;
      variant_reg <= VARIANT_SMALL;
      imp_sel_reg <= 6'h00;
      flash_addr_reg <= 12'h000;
      ee_addr_reg <= 9'h000;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        ADDR_CTRL: begin
          prog_mode_reg <= w_data_reg[CTRL_PROG_MODE_BIT];
          hv_mode_reg <= w_data_reg[CTRL_HV_MODE_BIT];
          legacy_reg <= w_data_reg[CTRL_LEGACY_BIT];
          variant_reg <= w_data_reg[CTRL_VARIANT_LSB +: 2];
        end
        ADDR_IMPRINT_SEL: imp_sel_reg <= w_data_reg[5:0];
        ADDR_FLASH_ADDR: flash_addr_reg <= w_data_reg[11:0];
        ADDR_EE_ADDR: ee_addr_reg <= w_data_reg[8:0];
        default: begin
        end
      endcase
    end
  end

  // working configuration: power-up, programming entry and exit latch the store
  logic boot_latch_reg;
  logic prog_mode_d_reg;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_reg <= FUSE_SET_RESET;
      boot_latch_reg <= 1'b1;
      prog_mode_d_reg <= 1'b0;
      ee_preserve_reg <= 1'b1;
    end else begin
      prog_mode_d_reg <= prog_mode_reg;
      boot_latch_reg <= 1'b0;
      if (boot_latch_reg || (prog_mode_reg != prog_mode_d_reg)) begin
        active_reg <= stored_reg;
      end
      // eeprom preserve bypasses the latch
      ee_preserve_reg <= stored_reg.high[HI_EE_PRESERVE_BIT];
    end
  end

  // calibration load at reset; leaving programming mode restarts the part, so reload
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cal_state_reg <= CAL_IDLE;
      osc_cal_reg <= OSC_CAL_RESET;
    end else begin
      unique case (cal_state_reg)
        CAL_IDLE: cal_state_reg <= CAL_LOAD;
        CAL_LOAD: begin
          osc_cal_reg <= legacy_reg ? CAL_6M4_BYTE : CAL_8M_BYTE;
          cal_state_reg <= CAL_DONE;
        end
        CAL_DONE: cal_state_reg <= (prog_mode_d_reg && !prog_mode_reg) ? CAL_LOAD : CAL_DONE;
        default: cal_state_reg <= CAL_IDLE;
      endcase
    end
  end

  // outputs from flip-flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_low_fuse_out <= FUSE_LOW_RESET;
      active_high_fuse_out <= FUSE_HIGH_RESET;
      self_program_enable_fuse_out <= 1'b0;
      eeprom_preserve_fuse_out <= 1'b0;
      oscillator_calibration_register_out <= OSC_CAL_RESET;
      calibration_done_out <= 1'b0;
    end else begin
      active_low_fuse_out <= active_reg.low;
      active_high_fuse_out <= active_reg.high;
      self_program_enable_fuse_out <= !active_reg.ext[EXT_SELF_PROG_BIT];
      eeprom_preserve_fuse_out <= !ee_preserve_reg;
      oscillator_calibration_register_out <= osc_cal_reg;
      calibration_done_out <= (cal_state_reg == CAL_DONE);
    end
  end

  a_fuse_lock_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    fuse_locked |=> $stable(stored_reg))
    else $error("fuse changed while locked");

  a_serial_dl_keep: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !hv_mode_reg |=> $stable(stored_reg.high[HI_SERIAL_DL_BIT]))
    else $error("serial download fuse changed outside high-voltage mode");

  a_erase_keeps_fuse: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (do_write && aw_addr_reg == ADDR_CTRL) |=> $stable(stored_reg))
    else $error("chip erase touched fuses");

  a_active_frozen: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (prog_mode_reg && prog_mode_d_reg && !boot_latch_reg) |=> $stable(active_reg))
    else $error("working fuses changed during programming");

  a_ee_preserve_fast: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $fell(stored_reg.high[HI_EE_PRESERVE_BIT]) |=> ##1 eeprom_preserve_fuse_out)
    else $error("eeprom preserve not applied at once");

  a_cal_source: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cal_state_reg == CAL_LOAD) |=> osc_cal_reg == (
      $past(legacy_reg) ? CAL_6M4_BYTE : CAL_8M_BYTE))
    else $error("wrong calibration byte loaded");

  a_hv_only_guard: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (hv_only && !hv_mode_reg) |=> $stable(stored_reg))
    else $error("fuse written outside high-voltage mode");

  a_ext_upper_ones: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    stored_reg.ext[7:1] == 7'h7F)
    else $error("unused extended fuse bits not one");

endmodule // fuse_signature_config_store

// >>> hdl/fuse_store_pkg.sv
package fuse_store_pkg;

  // axi4-lite register byte addresses
  localparam logic [7:0] ADDR_FUSE_LOW = 8'h00;
  localparam logic [7:0] ADDR_FUSE_HIGH = 8'h04;
  localparam logic [7:0] ADDR_FUSE_EXT = 8'h08;
  localparam logic [7:0] ADDR_LOCK = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_ACTIVE_LOW = 8'h14;
  localparam logic [7:0] ADDR_ACTIVE_HIGH = 8'h18;
  localparam logic [7:0] ADDR_ACTIVE_EXT = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_OSC_CAL = 8'h24;
  localparam logic [7:0] ADDR_IMPRINT_SEL = 8'h28;
  localparam logic [7:0] ADDR_IMPRINT_DATA = 8'h2C;
  localparam logic [7:0] ADDR_FLASH_ADDR = 8'h30;
  localparam logic [7:0] ADDR_FLASH_SPLIT = 8'h34;
  localparam logic [7:0] ADDR_EE_ADDR = 8'h38;
  localparam logic [7:0] ADDR_EE_SPLIT = 8'h3C;

  // ctrl register fields
  localparam int CTRL_PROG_MODE_BIT = 0;
  localparam int CTRL_HV_MODE_BIT = 1;
  localparam int CTRL_LEGACY_BIT = 2;
  localparam int CTRL_CHIP_ERASE_BIT = 3;
  localparam int CTRL_VARIANT_LSB = 4;

  // status register fields
  localparam int STAT_FUSE_LOCKED_BIT = 0;
  localparam int STAT_HV_ONLY_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;

  // high fuse field positions
  localparam int HI_RESET_DISABLE_BIT = 7;
  localparam int HI_DEBUG_ENABLE_BIT = 6;
  localparam int HI_SERIAL_DL_BIT = 5;
  localparam int HI_WATCHDOG_BIT = 4;
  localparam int HI_EE_PRESERVE_BIT = 3;
  localparam int HI_BROWNOUT_LSB = 0;

  // low fuse field positions
  localparam int LO_DIV8_BIT = 7;
  localparam int LO_CLKOUT_BIT = 6;
  localparam int LO_STARTUP_LSB = 4;
  localparam int LO_CLKSEL_LSB = 0;

  // extended fuse field
  localparam int EXT_SELF_PROG_BIT = 0;

  // lock byte field
  localparam int LOCK_FIRST_BIT = 0;

  // reset values: zero means programmed
  localparam logic [7:0] FUSE_LOW_RESET = 8'h62;
  localparam logic [7:0] FUSE_HIGH_RESET = 8'hDF;
  localparam logic [7:0] FUSE_EXT_RESET = 8'hFF;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [7:0] OSC_CAL_RESET = 8'h00;

  // imprint table addresses
  localparam logic [5:0] IMP_SIG0 = 6'h00;
  localparam logic [5:0] IMP_CAL_8M = 6'h01;
  localparam logic [5:0] IMP_SIG1 = 6'h02;
  localparam logic [5:0] IMP_CAL_6M4 = 6'h03;
  localparam logic [5:0] IMP_SIG2 = 6'h04;
  localparam logic [7:0] IMP_RESERVED_DATA = 8'hFF;

  // page split
  localparam int FLASH_WORD_BITS_SMALL = 4;
  localparam int FLASH_WORD_BITS_LARGE = 5;
  localparam int EE_BYTE_BITS = 2;
  localparam logic [1:0] VARIANT_SMALL = 2'h0;

  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } fuse_set_t;

  localparam fuse_set_t FUSE_SET_RESET = '{ext: FUSE_EXT_RESET, high: FUSE_HIGH_RESET,
                                           low: FUSE_LOW_RESET};

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_LOAD = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_t;

endpackage

// >>> verif/fuse_programmer_model.sv
module fuse_programmer_model (
  input wire logic clk_in,
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    awaddr_out = 8'h00;
    awvalid_out = 1'b0;
    wdata_out = 32'h0;
    wstrb_out = 4'hF;
    wvalid_out = 1'b0;
    bready_out = 1'b0;
    araddr_out = 8'h00;
    arvalid_out = 1'b0;
    rready_out = 1'b0;
  end

  // released payload is inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    fork
      begin
        do @(posedge clk_in); while (awready_in !== 1'b1);
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      begin
        do @(posedge clk_in); while (wready_in !== 1'b1);
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
    join
    while (bvalid_in !== 1'b1) @(posedge clk_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do @(posedge clk_in); while (arready_in !== 1'b1);
    arvalid_out <= 1'b0;
    araddr_out <= ~a;
    while (rvalid_in !== 1'b1) @(posedge clk_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule // fuse_programmer_model

// >>> verif/fuse_signature_config_store_tb.sv
module fuse_signature_config_store_tb
  import fuse_store_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] awaddr, araddr, act_lo, act_hi, cal;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, spe, eep, cal_done;
  int miscompares = 0;
  int checks_done = 0;
  // signature and calibration values are arbitrary
  logic [7:0] imp [5] = '{8'hC3, 8'h9A, 8'h4D, 8'h61, 8'h27};

  always #12.5 core_clk_in = ~core_clk_in;

  fuse_signature_config_store #(
    .SIG_BYTE0(8'hC3),
    .SIG_BYTE1(8'h4D),
    .SIG_BYTE2(8'h27),
    .CAL_8M_BYTE(8'h9A),
    .CAL_6M4_BYTE(8'h61)
  ) u_dut (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready),
    .active_low_fuse_out(act_lo),
    .active_high_fuse_out(act_hi),
    .self_program_enable_fuse_out(spe),
    .eeprom_preserve_fuse_out(eep),
    .oscillator_calibration_register_out(cal),
    .calibration_done_out(cal_done)
  );

  fuse_programmer_model u_prog (
    .clk_in(core_clk_in),
    .awaddr_out(awaddr),
    .awvalid_out(awvalid),
    .awready_in(awready),
    .wdata_out(wdata),
    .wstrb_out(wstrb),
    .wvalid_out(wvalid),
    .wready_in(wready),
    .bresp_in(bresp),
    .bvalid_in(bvalid),
    .bready_out(bready),
    .araddr_out(araddr),
    .arvalid_out(arvalid),
    .arready_in(arready),
    .rdata_in(rdata),
    .rresp_in(rresp),
    .rvalid_in(rvalid),
    .rready_out(rready)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    u_prog.wr(a, d, resp);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    u_prog.rd(a, rd_data, resp);
    check(rd_data, e);
  endtask

  // outputs are registered: let latching land before looking
  task automatic settle();
    repeat (3) @(posedge core_clk_in);
  endtask

  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (12) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    print_verdict();
  end

  initial begin
    do_reset();
    check({24'h0, act_lo}, 32'h62);
    check({24'h0, act_hi}, 32'hDF);
    check({31'h0, spe}, 32'h0);
    check({31'h0, eep}, 32'h0);
    check({24'h0, cal}, 32'h9A);
    check({31'h0, cal_done}, 32'h1);
    rc(ADDR_FUSE_HIGH, 32'hDF);
    rc(ADDR_FUSE_EXT, 32'hFF);
    rc(ADDR_ACTIVE_LOW, 32'h62);
    // serial session: bit 5 set on purpose, it must not stick
    w(ADDR_CTRL, 32'h01);
    w(ADDR_FUSE_LOW, 32'h3F);
    w(ADDR_FUSE_HIGH, 32'hF7);
    w(ADDR_FUSE_EXT, 32'hFE);
    settle();
    rc(ADDR_FUSE_HIGH, 32'hD7);
    check({31'h0, eep}, 32'h1);
    check({24'h0, act_lo}, 32'h62);
    check({31'h0, spe}, 32'h0);
    w(ADDR_CTRL, 32'h09);
    rc(ADDR_FUSE_LOW, 32'h3F);
    w(ADDR_CTRL, 32'h00);
    settle();
    check({24'h0, act_lo}, 32'h3F);
    w(ADDR_CTRL, 32'h01);
    settle();
    check({24'h0, act_lo}, 32'h3F);
    check({24'h0, act_hi}, 32'hD7);
    check({31'h0, spe}, 32'h1);
    // fuses are final and debug stays unprogrammed before locking
    w(ADDR_LOCK, 32'hFE);
    w(ADDR_FUSE_LOW, 32'h62);
    rc(ADDR_FUSE_LOW, 32'h3F);
    rc(ADDR_STATUS, 32'h05);
    w(ADDR_CTRL, 32'h03);
    w(ADDR_FUSE_LOW, 32'h62);
    rc(ADDR_FUSE_LOW, 32'h3F);
    for (int m = 1; m < 4; m += 2) begin
      w(ADDR_CTRL, 32'(m));
      // reserved imprint addresses hold nothing dependable, so they are never compared
      for (int i = 0; i < 5; i++) begin
        w(ADDR_IMPRINT_SEL, 32'(i));
        rc(ADDR_IMPRINT_DATA, {24'h0, imp[i]});
      end
    end
    // second reset clears the lock and returns the store to defaults
    do_reset();
    w(ADDR_CTRL, 32'h01);
    w(ADDR_FUSE_HIGH, 32'h9F);
    w(ADDR_FUSE_LOW, 32'h00);
    rc(ADDR_FUSE_LOW, 32'h62);
    rc(ADDR_STATUS, 32'h06);
    w(ADDR_CTRL, 32'h03);
    w(ADDR_FUSE_LOW, 32'h00);
    rc(ADDR_FUSE_LOW, 32'h00);
    w(ADDR_CTRL, 32'h00);
    w(ADDR_FLASH_ADDR, 32'h3BC);
    rc(ADDR_FLASH_SPLIT, 32'h003B000C);
    w(ADDR_CTRL, 32'h10);
    rc(ADDR_FLASH_SPLIT, 32'h001D001C);
    w(ADDR_EE_ADDR, 32'h1AB);
    rc(ADDR_EE_SPLIT, 32'h006A0003);
    // legacy mode chosen inside programming mode, then applied by the restart on leaving it
    w(ADDR_CTRL, 32'h05);
    w(ADDR_CTRL, 32'h04);
    settle();
    check({24'h0, cal}, 32'h61);
    rc(ADDR_OSC_CAL, 32'h61);
    rc(8'h40, 32'h0);
    check({30'h0, resp}, 32'h2);
    w(8'h44, 32'h0);
    check({30'h0, resp}, 32'h2);
    print_verdict();
  end
endmodule // fuse_signature_config_store_tb
